// ---- verilog/ppl_probe_map.vh ----
// Constants for the probe position latch block.
// Summary of operation
// - Edge-select bit 0 set arms capture on probe rising edges; clear ignores them.
// - Edge-select bit 1 set arms capture on probe falling edges; clear ignores them.
// - Edge-select word picks edges during the probing procedure; upper bits are reserved.
// - Storing a measured position sets that edge's status bit in the same update.
// - Master clearing the arm bit while the procedure is active clears status bits 0 and 1.
// - Status bits already set stay set when their edges are later deselected.
// - Arm bit is evaluated only while the probing procedure is active.
// - Arm bit may arrive as a real-time control bit in the cyclic telegram.
// - After a capture, that edge is blocked until arm is cleared and set again.
// - Rising capture latches position into its register with the rising status bit.
// - Master may measure repeatedly while active and cancels the procedure when done.
`ifndef PPL_PROBE_MAP_VH
`define PPL_PROBE_MAP_VH

`define PPL_WORD_W        16
`define PPL_SEL_RISE_BIT  0
`define PPL_SEL_FALL_BIT  1
`define PPL_STAT_RISE_BIT 0
`define PPL_STAT_FALL_BIT 1
`define PPL_ARM_BIT       0
`define PPL_SEL_USED_MASK 16'h0003
`define PPL_WORD_RESET    16'h0000
`define PPL_POS_W         32

`endif

// ---- verilog/ppl_probe_edge.v ----
// Probe input synchroniser and single-cycle edge detector.
`timescale 1ns/100ps
module ppl_probe_edge
(
    clk_sys,
    reset_n,
    probe_pin,
    rise_pulse,
    fall_pulse
);
    input  wire clk_sys;
    input  wire reset_n;
    input  wire probe_pin;
    output reg  rise_pulse;
    output reg  fall_pulse;

    reg         sync1_q;
    reg         sync2_q;
    reg         prev_q;

    // The first stage feeds only the second stage, so metastability stays contained.
    always @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            sync1_q    <= 1'b0;
            sync2_q    <= 1'b0;
            prev_q     <= 1'b0;
            rise_pulse <= 1'b0;
            fall_pulse <= 1'b0;
        end
        else
        begin
            sync1_q    <= probe_pin;
            sync2_q    <= sync1_q;
            prev_q     <= sync2_q;
            rise_pulse <= sync2_q & ~prev_q;
            fall_pulse <= ~sync2_q & prev_q;
        end
    end
endmodule // ppl_probe_edge

// ---- verilog/ppl_probe_latch.v ----
// Touch-probe capture control: edge selection, arming and capture status.
`timescale 1ns/100ps
`include "ppl_probe_map.vh"
module ppl_probe_latch
#(
    parameter POS_W = `PPL_POS_W
)
(
    clk_sys,
    reset_n,
    probe_pin,
    pos_feedback,
    proc_active,
    sel_wr_en,
    sel_wr_data,
    arm_wr_en,
    arm_wr_data,
    mdt_arm_valid,
    mdt_arm_bit,
    edge_select_q,
    capture_status_q,
    arm_word_q,
    pos_rise_q,
    pos_fall_q
);
    // Clock and synchronous reset.
    input  wire                   clk_sys;
    input  wire                   reset_n;

    // Probe pin, asynchronous to the clock, and the position it captures.
    input  wire                   probe_pin;
    input  wire [POS_W-1:0]       pos_feedback;

    // Procedure command and edge-select parameter write.
    input  wire                   proc_active;
    input  wire                   sel_wr_en;
    input  wire [`PPL_WORD_W-1:0] sel_wr_data;

    // Arm bit, from a parameter write or from the cyclic telegram.
    input  wire                   arm_wr_en;
    input  wire [`PPL_WORD_W-1:0] arm_wr_data;
    input  wire                   mdt_arm_valid;
    input  wire                   mdt_arm_bit;

    // Readback registers and latched positions.
    output reg  [`PPL_WORD_W-1:0] edge_select_q;
    output reg  [`PPL_WORD_W-1:0] capture_status_q;
    output reg  [`PPL_WORD_W-1:0] arm_word_q;
    output reg  [POS_W-1:0]       pos_rise_q;
    output reg  [POS_W-1:0]       pos_fall_q;

    // Single-cycle probe edge events.
    wire                          rise_pulse;
    wire                          fall_pulse;

    // Arm source selection and disarm detection.
    reg                           arm_prev_q;
    reg                           arm_d;
    reg  [`PPL_WORD_W-1:0]        arm_word_d;
    wire                          arm_now;
    wire                          arm_cleared;

    // Next values of the readback registers and the qualified captures.
    reg  [`PPL_WORD_W-1:0]        edge_select_d;
    reg  [`PPL_WORD_W-1:0]        status_d;
    wire                          cap_rise;
    wire                          cap_fall;

    ////////////////////////////////////////////////////////////////////////////////

    // A selected edge counts only inside the procedure, with the arm bit high,
    // and only while its own status bit is still clear.
    function qualify_edge;
        input active;
        input armed;
        input selected;
        input pulse;
        input captured;
        begin
            qualify_edge = active & armed & selected & pulse & ~captured;
        end
    endfunction

    // Set wins over clear, so an event in the clearing cycle is never lost.
    function next_status;
        input current;
        input clear;
        input set;
        begin
            next_status = set | (current & ~clear);
        end
    endfunction

    // A position register moves only in the cycle of its own capture.
    function [POS_W-1:0] next_position;
        input [POS_W-1:0] current;
        input [POS_W-1:0] sample;
        input             take;
        begin
            next_position = take ? sample : current;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    // Edge events lag the pin by three clocks; the position is taken one clock later.
    ppl_probe_edge u_edge
    (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .probe_pin  (probe_pin),
        .rise_pulse (rise_pulse),
        .fall_pulse (fall_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////////

    // The telegram bit and a parameter write both land in the same arm word; the
    // telegram wins when both arrive together since it is the cyclic source.
    always @*
    begin
        arm_d = arm_word_q[`PPL_ARM_BIT];
        if (arm_wr_en)
            arm_d = arm_wr_data[`PPL_ARM_BIT];
        if (mdt_arm_valid)
            arm_d = mdt_arm_bit;
    end

    assign arm_now     = arm_word_q[`PPL_ARM_BIT];
    // Outside the procedure the arm bit has no effect at all.
    assign arm_cleared = proc_active & arm_prev_q & ~arm_now;

    // An edge already captured keeps its status bit set, which blocks that edge
    // until the arm bit is cleared and set again.
    assign cap_rise = qualify_edge(proc_active,
                                   arm_now,
                                   edge_select_q[`PPL_SEL_RISE_BIT],
                                   rise_pulse,
                                   capture_status_q[`PPL_STAT_RISE_BIT]);
    assign cap_fall = qualify_edge(proc_active,
                                   arm_now,
                                   edge_select_q[`PPL_SEL_FALL_BIT],
                                   fall_pulse,
                                   capture_status_q[`PPL_STAT_FALL_BIT]);

    // Only the low bit of the arm word is stored; the rest reads back as zero.
    always @*
    begin
        arm_word_d               = `PPL_WORD_RESET;
        arm_word_d[`PPL_ARM_BIT] = arm_d;
    end

    // Reserved upper select bits are not stored and read back as zero.
    always @*
    begin
        edge_select_d = edge_select_q;
        if (sel_wr_en)
            edge_select_d = sel_wr_data & `PPL_SEL_USED_MASK;
    end

    // Deselecting an edge never touches status; only a disarm clears it. A capture
    // cannot meet a disarm since capture needs the arm bit high.
    always @*
    begin
        status_d                     = `PPL_WORD_RESET;
        status_d[`PPL_STAT_RISE_BIT] = next_status(capture_status_q[`PPL_STAT_RISE_BIT],
                                                   arm_cleared,
                                                   cap_rise);
        status_d[`PPL_STAT_FALL_BIT] = next_status(capture_status_q[`PPL_STAT_FALL_BIT],
                                                   arm_cleared,
                                                   cap_fall);
    end

    ////////////////////////////////////////////////////////////////////////////////

    always @(posedge clk_sys)
    begin
        if (!reset_n)
            edge_select_q <= `PPL_WORD_RESET;
        else
            edge_select_q <= edge_select_d;
    end

    // The previous arm value marks a falling arm bit for the disarm clear.
    always @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            arm_word_q <= `PPL_WORD_RESET;
            arm_prev_q <= 1'b0;
        end
        else
        begin
            arm_word_q <= arm_word_d;
            arm_prev_q <= arm_now;
        end
    end

    // Leaving the procedure keeps status and positions, so the master can still
    // read the results after cancelling it.
    always @(posedge clk_sys)
    begin
        if (!reset_n)
            capture_status_q <= `PPL_WORD_RESET;
        else
            capture_status_q <= status_d;
    end

    always @(posedge clk_sys)
    begin
        if (!reset_n)
            pos_rise_q <= {POS_W{1'b0}};
        else
            pos_rise_q <= next_position(pos_rise_q, pos_feedback, cap_rise);
    end

    always @(posedge clk_sys)
    begin
        if (!reset_n)
            pos_fall_q <= {POS_W{1'b0}};
        else
            pos_fall_q <= next_position(pos_fall_q, pos_feedback, cap_fall);
    end
endmodule // ppl_probe_latch

// ---- dv/ppl_master_model.sv ----
// Master-side model: telegram arm bit, probe signal and position feedback.
`timescale 1ns/100ps
module ppl_master_model
(
    input  wire        clk_sys,
    output logic       probe_pin = 1'b0,
    output logic [31:0] pos_feedback = 32'h0,
    output logic       mdt_arm_valid = 1'b0,
    output logic       mdt_arm_bit = 1'b0
);
    // The bit is inverted once invalid so a stale value is never mistaken for a live one.
    task send_arm(input logic b);
        @(posedge clk_sys) #1 {mdt_arm_valid, mdt_arm_bit} = {1'b1, b};
        @(posedge clk_sys) #1 mdt_arm_valid = 1'b0;
        mdt_arm_bit = ~b;
    endtask
    // Position holds long enough to cover the synchroniser delay, then changes.
    task probe(input logic v, input logic [31:0] p);
        @(posedge clk_sys) #1 {probe_pin, pos_feedback} = {v, p};
        repeat (6) @(posedge clk_sys);
        #1 pos_feedback = ~p;
    endtask
endmodule // ppl_master_model

// ---- dv/ppl_probe_monitor.sv ----
// Assertion checker for the probe position latch ports.
`timescale 1ns/100ps
module ppl_probe_monitor #(parameter POS_W = 32)
(
    input wire             clk_sys,
    input wire             reset_n,
    input wire             probe_pin,
    input wire             proc_active,
    input wire             sel_wr_en,
    input wire             arm_wr_en,
    input wire             mdt_arm_valid,
    input wire             mdt_arm_bit,
    input wire [POS_W-1:0] pos_feedback,
    input wire [POS_W-1:0] pos_rise_q,
    input wire [POS_W-1:0] pos_fall_q,
    input wire [15:0]      sel_wr_data,
    input wire [15:0]      arm_wr_data,
    input wire [15:0]      edge_select_q,
    input wire [15:0]      capture_status_q,
    input wire [15:0]      arm_word_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_rise_qualified: assert property ($rose(capture_status_q[0]) |->
        $past(edge_select_q[0] && arm_word_q[0] && proc_active)) else $error("bad rise");
    a_fall_qualified: assert property ($rose(capture_status_q[1]) |->
        $past(edge_select_q[1] && arm_word_q[0] && proc_active)) else $error("bad fall");
    a_rise_pos_latch: assert property ($rose(capture_status_q[0]) |->
        pos_rise_q == $past(pos_feedback)) else $error("rise position");
    a_disarm_clears: assert property ($fell(arm_word_q[0]) && proc_active |=>
        capture_status_q[1:0] == 2'b00) else $error("status not cleared");
    a_reserved_zero: assert property (
        edge_select_q[15:2] == 14'h0 && capture_status_q[15:2] == 14'h0) else $error("reserved");
    a_status_kept: assert property (capture_status_q[0] && arm_word_q[0] |=>
        capture_status_q[0]) else $error("status lost");
    a_no_recapture: assert property (capture_status_q[0] && $past(capture_status_q[0]) |->
        $stable(pos_rise_q)) else $error("recapture");
    a_sel_write: assert property (sel_wr_en |=>
        edge_select_q == ($past(sel_wr_data) & 16'h0003)) else $error("select write");
    a_tel_arm: assert property (mdt_arm_valid |=>
        arm_word_q[0] == $past(mdt_arm_bit)) else $error("telegram arm");
    a_inactive_hold: assert property (!proc_active |=>
        $stable(capture_status_q)) else $error("status moved while inactive");
    c_rise: cover property ($rose(capture_status_q[0]));
    c_fall: cover property ($rose(capture_status_q[1]));
    c_clear: cover property ($fell(capture_status_q[0]));
endmodule // ppl_probe_monitor

// ---- dv/tb_ppl_probe_latch.sv ----
// Directed testbench for the probe position latch.
`timescale 1ns/100ps
module tb_ppl_probe_latch;
    logic        clk_sys, reset_n, proc_active, sel_wr_en, arm_wr_en;
    logic [15:0] wd;
    wire         probe_pin, mdt_arm_valid, mdt_arm_bit;
    wire  [31:0] pos_feedback, pos_rise_q, pos_fall_q;
    wire  [15:0] edge_select_q, capture_status_q, arm_word_q;
    int          err_count = 0, tests_run = 0;
    ppl_master_model m (.clk_sys, .probe_pin, .pos_feedback, .mdt_arm_valid, .mdt_arm_bit);
    ppl_probe_latch dut (.clk_sys, .reset_n, .probe_pin, .pos_feedback, .proc_active, .sel_wr_en,
        .sel_wr_data(wd), .arm_wr_en, .arm_wr_data(wd), .mdt_arm_valid, .mdt_arm_bit,
        .edge_select_q, .capture_status_q, .arm_word_q, .pos_rise_q, .pos_fall_q);
    task test_done;
        $display("tests_run=%0d err_count=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) err_count++;
        if (g !== e) $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    endtask
    task wr(input logic a, input logic [15:0] d);
        @(posedge clk_sys) #1 {arm_wr_en, sel_wr_en, wd} = {a, !a, d};
        @(posedge clk_sys) #1 {arm_wr_en, sel_wr_en} = 2'b00;
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial
    begin
        repeat (2000) @(posedge clk_sys);
        err_count++;
        test_done;
    end
    initial
    begin
        {reset_n, proc_active, sel_wr_en, arm_wr_en, wd} = '0;
        repeat (5) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        @(posedge clk_sys) #1 chk({edge_select_q, capture_status_q}, 32'h0);
        chk({arm_word_q, pos_rise_q[15:0]}, 32'h0);
        wr(1'b0, 16'hFFFF); chk(edge_select_q, 32'h3);
        wr(1'b0, 16'h0001); wr(1'b1, 16'h0001);
        m.probe(1'b1, 32'h11); chk(capture_status_q, 32'h0);
        m.probe(1'b0, 32'h22); proc_active = 1'b1;
        m.probe(1'b1, 32'hA5A50001); chk(capture_status_q, 32'h1);
        chk(pos_rise_q, 32'hA5A50001);
        m.probe(1'b0, 32'h2); chk({capture_status_q, pos_fall_q[15:0]}, 32'h10000);
        m.probe(1'b1, 32'h3); chk(pos_rise_q, 32'hA5A50001);
        wr(1'b0, 16'h0002); chk(capture_status_q, 32'h1);
        m.probe(1'b0, 32'h44); chk(capture_status_q, 32'h3);
        chk(pos_fall_q, 32'h44);
        m.send_arm(1'b0); chk(arm_word_q, 32'h0);
        @(posedge clk_sys) #1 chk(capture_status_q, 32'h0);
        m.send_arm(1'b1); chk(arm_word_q, 32'h1);
        wr(1'b0, 16'h0001); chk(edge_select_q, 32'h1);
        m.probe(1'b1, 32'h55); chk(pos_rise_q, 32'h55);
        proc_active = 1'b0;
        m.send_arm(1'b0); @(posedge clk_sys) #1 chk(capture_status_q, 32'h1);
        test_done;
    end
endmodule // tb_ppl_probe_latch
bind ppl_probe_latch ppl_probe_monitor #(.POS_W(POS_W)) mon (
    .clk_sys(clk_sys), .reset_n(reset_n), .probe_pin(probe_pin), .proc_active(proc_active),
    .sel_wr_en(sel_wr_en), .arm_wr_en(arm_wr_en), .mdt_arm_valid(mdt_arm_valid),
    .mdt_arm_bit(mdt_arm_bit), .pos_feedback(pos_feedback), .pos_rise_q(pos_rise_q),
    .pos_fall_q(pos_fall_q), .sel_wr_data(sel_wr_data), .arm_wr_data(arm_wr_data),
    .edge_select_q(edge_select_q), .capture_status_q(capture_status_q),
    .arm_word_q(arm_word_q));
